// ==== rtl/xlp_pkg.sv ====
`default_nettype none
package xlp_pkg;
  localparam int          LANE_W      = 32;
  localparam int          FLAG_W      = 4;
  localparam int          PAIR_W      = 2 * LANE_W;
  localparam int          PFLAG_W     = 2 * FLAG_W;
  localparam int          BUF_DEPTH   = 2;
  localparam logic [1:0]  BUF_FULL    = 2'h2;
  localparam logic [1:0]  CNT_RST     = 2'h0;
  localparam logic [31:0] IDLE_WORD   = 32'h07070707;
  localparam logic [3:0]  IDLE_FLAGS  = 4'hf;
  localparam logic [31:0] WORD_RST    = 32'h07070707;
  localparam logic [3:0]  FLAGS_RST   = 4'hf;
endpackage
`default_nettype wire

// ==== rtl/xlp_lane_port.sv ====
`default_nettype none
module xlp_lane_port
  import xlp_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_tx_ddr_clock,
  input  wire logic [LANE_W-1:0]  i_tx_lane_word,
  input  wire logic [FLAG_W-1:0]  i_tx_ctrl_flags,
  output logic      [PAIR_W-1:0]  o_tx_word,
  output logic      [PFLAG_W-1:0] o_tx_flags,
  output logic                    o_tx_valid,
  input  wire logic               i_tx_ready,
  output logic                    o_tx_overflow,
  input  wire logic               i_rx_ref_clock,
  output logic                    o_rx_ddr_clock,
  output logic      [LANE_W-1:0]  o_rx_lane_word,
  output logic      [FLAG_W-1:0]  o_rx_ctrl_flags,
  input  wire logic [PAIR_W-1:0]  i_rx_word,
  input  wire logic [PFLAG_W-1:0] i_rx_flags,
  input  wire logic               i_rx_valid,
  output logic                    o_rx_ready,
  output logic                    o_rx_underrun
);
  localparam int ENT_W = PAIR_W + PFLAG_W;

  // Transmit side: the link clock and its data pass two flops before use.
  logic              tclk_s1_r, tclk_s2_r, tclk_s3_r;
  logic [LANE_W-1:0] td_s1_r, td_s2_r;
  logic [FLAG_W-1:0] tk_s1_r, tk_s2_r;
  logic              tx_rise, tx_fall;
  logic [LANE_W-1:0] lo_word_r;
  logic [FLAG_W-1:0] lo_flags_r;
  logic              half_r;
  logic              tx_push, tx_pop;
  logic [ENT_W-1:0]  tx_mem_r [BUF_DEPTH];
  logic              tx_wp_r, tx_rp_r;
  logic [1:0]        tx_cnt_r;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tclk_s1_r <= 1'b0;
      tclk_s2_r <= 1'b0;
      tclk_s3_r <= 1'b0;
      td_s1_r   <= WORD_RST;
      td_s2_r   <= WORD_RST;
      tk_s1_r   <= FLAGS_RST;
      tk_s2_r   <= FLAGS_RST;
    end else begin
      tclk_s1_r <= i_tx_ddr_clock;
      tclk_s2_r <= tclk_s1_r;
      tclk_s3_r <= tclk_s2_r;
      td_s1_r   <= i_tx_lane_word;
      td_s2_r   <= td_s1_r;
      tk_s1_r   <= i_tx_ctrl_flags;
      tk_s2_r   <= tk_s1_r;
    end
  end

  assign tx_rise = tclk_s2_r & ~tclk_s3_r;
  assign tx_fall = ~tclk_s2_r & tclk_s3_r;

  // Word and flags are taken together, relying on the partner holding both across each edge.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      lo_word_r  <= WORD_RST;
      lo_flags_r <= FLAGS_RST;
      half_r     <= 1'b0;
    end else if (tx_rise) begin
      lo_word_r  <= td_s2_r;
      lo_flags_r <= tk_s2_r;
      half_r     <= 1'b1;
    end else if (tx_fall) begin
      half_r     <= 1'b0;
    end
  end

  // A falling edge without a prior rising half is dropped so pairs never slip.
  assign tx_push = tx_fall & half_r & (tx_cnt_r != BUF_FULL);
  assign tx_pop  = o_tx_valid & i_tx_ready;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tx_wp_r  <= 1'b0;
      tx_rp_r  <= 1'b0;
      tx_cnt_r <= CNT_RST;
    end else begin
      if (tx_push) begin
        tx_wp_r <= ~tx_wp_r;
      end
      if (tx_pop) begin
        tx_rp_r <= ~tx_rp_r;
      end
      tx_cnt_r <= tx_cnt_r + {1'b0, tx_push} - {1'b0, tx_pop};
    end
  end

  // Flags stay beside their byte lanes: flag n of each half covers byte n of that half.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        tx_mem_r[i] <= '0;
      end
    end else if (tx_push) begin
      tx_mem_r[tx_wp_r] <= {tk_s2_r, lo_flags_r, td_s2_r, lo_word_r};
    end
  end

  // The link cannot be stalled, so a word arriving into a full buffer is reported.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_tx_overflow <= 1'b0;
    end else begin
      o_tx_overflow <= tx_fall & half_r & (tx_cnt_r == BUF_FULL);
    end
  end

  assign o_tx_valid = (tx_cnt_r != CNT_RST);
  assign o_tx_word  = tx_mem_r[tx_rp_r][PAIR_W-1:0];
  assign o_tx_flags = tx_mem_r[tx_rp_r][ENT_W-1:PAIR_W];

  // Receive side: the reference clock is synchronised and alone paces the receive clock.
  logic              ref_s1_r, ref_s2_r, ref_s3_r, ref_s4_r;
  logic              rx_rise, rx_fall;
  logic              rx_push, rx_pop;
  logic [ENT_W-1:0]  rx_mem_r [BUF_DEPTH];
  logic [ENT_W-1:0]  rx_head;
  logic              rx_wp_r, rx_rp_r;
  logic [1:0]        rx_cnt_r;
  logic [LANE_W-1:0] hi_word_r;
  logic [FLAG_W-1:0] hi_flags_r;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
      ref_s4_r <= 1'b0;
    end else begin
      ref_s1_r <= i_rx_ref_clock;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
      ref_s4_r <= ref_s3_r;
    end
  end

  assign rx_rise = ref_s2_r & ~ref_s3_r;
  assign rx_fall = ~ref_s2_r & ref_s3_r;
  // The clock lags the data by one cycle, giving the partner setup margin at each edge.
  assign o_rx_ddr_clock = ref_s4_r;

  assign rx_push    = i_rx_valid & o_rx_ready;
  assign rx_pop     = rx_rise & (rx_cnt_r != CNT_RST);
  assign o_rx_ready = (rx_cnt_r != BUF_FULL);
  assign rx_head    = rx_mem_r[rx_rp_r];

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rx_wp_r  <= 1'b0;
      rx_rp_r  <= 1'b0;
      rx_cnt_r <= CNT_RST;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        rx_mem_r[i] <= '0;
      end
    end else begin
      if (rx_push) begin
        rx_mem_r[rx_wp_r] <= {i_rx_flags, i_rx_word};
        rx_wp_r           <= ~rx_wp_r;
      end
      if (rx_pop) begin
        rx_rp_r <= ~rx_rp_r;
      end
      rx_cnt_r <= rx_cnt_r + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end

  // An empty buffer sends idle control characters so every edge still carries a word.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rx_lane_word  <= WORD_RST;
      o_rx_ctrl_flags <= FLAGS_RST;
      hi_word_r       <= WORD_RST;
      hi_flags_r      <= FLAGS_RST;
      o_rx_underrun   <= 1'b0;
    end else begin
      o_rx_underrun <= rx_rise & (rx_cnt_r == CNT_RST);
      if (rx_rise) begin
        if (rx_cnt_r != CNT_RST) begin
          o_rx_lane_word  <= rx_head[LANE_W-1:0];
          o_rx_ctrl_flags <= rx_head[PAIR_W+FLAG_W-1:PAIR_W];
          hi_word_r       <= rx_head[PAIR_W-1:LANE_W];
          hi_flags_r      <= rx_head[ENT_W-1:PAIR_W+FLAG_W];
        end else begin
          o_rx_lane_word  <= IDLE_WORD;
          o_rx_ctrl_flags <= IDLE_FLAGS;
          hi_word_r       <= IDLE_WORD;
          hi_flags_r      <= IDLE_FLAGS;
        end
      end else if (rx_fall) begin
        o_rx_lane_word  <= hi_word_r;
        o_rx_ctrl_flags <= hi_flags_r;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_tx_pair;
    tx_rise ##[1:20] (tx_fall && half_r && tx_cnt_r == CNT_RST);
  endsequence

  a_tx_word_rise: assert property (tx_rise |=> lo_word_r == $past(td_s2_r))
    else $error("rising tx word not captured");
  a_tx_flag_rise: assert property (tx_rise |=> lo_flags_r == $past(tk_s2_r))
    else $error("rising tx flags not captured");
  a_tx_pair_order: assert property (s_tx_pair |=>
      o_tx_valid && o_tx_word[LANE_W-1:0] == $past(lo_word_r)
      && o_tx_word[PAIR_W-1:LANE_W] == $past(td_s2_r))
    else $error("tx pair halves out of order");
  a_tx_flag_lanes: assert property (s_tx_pair |=>
      o_tx_flags == {$past(tk_s2_r), $past(lo_flags_r)})
    else $error("tx flags not beside their lanes");
  a_rx_clock_src: assert property (rx_rise |=> ##1 o_rx_ddr_clock)
    else $error("rx clock does not follow reference");
  a_rx_rise_word: assert property (rx_rise && rx_cnt_r != CNT_RST |=>
      o_rx_lane_word == $past(rx_head[LANE_W-1:0]) && !o_rx_ddr_clock ##1 o_rx_ddr_clock)
    else $error("rx first half not driven before clock rise");
  a_rx_fall_word: assert property (rx_fall |=>
      o_rx_lane_word == $past(hi_word_r) && o_rx_ctrl_flags == $past(hi_flags_r))
    else $error("rx second half or flags misaligned");
  a_rx_idle_ctrl: assert property (rx_rise && rx_cnt_r == CNT_RST |=>
      o_rx_ctrl_flags == IDLE_FLAGS && o_rx_underrun)
    else $error("idle rx bytes not flagged as control");
  a_rx_flag_lanes: assert property (rx_rise && rx_cnt_r != CNT_RST |=>
      o_rx_ctrl_flags == $past(rx_head[PAIR_W+FLAG_W-1:PAIR_W]))
    else $error("rx flags not beside their lanes");
endmodule
`default_nettype wire

// ==== verification/xlp_mac_model.sv ====
`default_nettype none
module xlp_mac_model
  import xlp_pkg::*;
(
  output logic              o_tx_ddr_clock,
  output logic [LANE_W-1:0] o_tx_lane_word,
  output logic [FLAG_W-1:0] o_tx_ctrl_flags,
  output logic              o_rx_ref_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_tx_ddr_clock  = 1'b0;
    o_tx_lane_word  = IDLE_WORD;
    o_tx_ctrl_flags = IDLE_FLAGS;
    o_rx_ref_clock  = 1'b0;
    #3;
    // Slower than nominal so that the 200 MHz core can follow it.
    forever #24 o_rx_ref_clock = ~o_rx_ref_clock;
  end
  // The clock stands low between pairs; data settles 4 ns before each edge.
  task automatic send(input logic [PAIR_W-1:0] w, input logic [PFLAG_W-1:0] f);
    o_tx_lane_word  = w[LANE_W-1:0];
    o_tx_ctrl_flags = f[FLAG_W-1:0];
    #4 o_tx_ddr_clock = 1'b1;
    #20 o_tx_lane_word = w[PAIR_W-1:LANE_W];
    o_tx_ctrl_flags = f[PFLAG_W-1:FLAG_W];
    #4 o_tx_ddr_clock = 1'b0;
    // The core needs up to one 5 ns period to see the fall, so hold well past that.
    #12 o_tx_lane_word = ~o_tx_lane_word;
    o_tx_ctrl_flags = ~o_tx_ctrl_flags;
    #8;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import xlp_pkg::*;
  `define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
  logic                      clk, nrst, tdclk, rref, tx_ready, rx_valid, rclk_q, idl, und_q;
  logic [LANE_W-1:0]         tword;
  logic [FLAG_W-1:0]         tflags;
  logic [PAIR_W-1:0]         rx_word;
  logic [PFLAG_W-1:0]        rx_flags;
  logic [PAIR_W+PFLAG_W-1:0] txq[$], rxq[$], cur, e, t;
  wire logic [PAIR_W-1:0]    o_tx_word;
  wire logic [PFLAG_W-1:0]   o_tx_flags;
  wire logic                 o_tx_valid, o_tx_overflow, o_rx_ddr_clock, o_rx_ready;
  wire logic [LANE_W-1:0]    o_rx_lane_word;
  wire logic [FLAG_W-1:0]    o_rx_ctrl_flags;
  wire logic                 o_rx_underrun;
  int                        fails, total_checks, ovf, rxe;
  xlp_mac_model mac (.o_tx_ddr_clock(tdclk), .o_tx_lane_word(tword),
    .o_tx_ctrl_flags(tflags), .o_rx_ref_clock(rref));
  xlp_lane_port dut (.i_clk(clk), .i_nrst(nrst), .i_tx_ddr_clock(tdclk),
    .i_tx_lane_word(tword), .i_tx_ctrl_flags(tflags), .o_tx_word(o_tx_word),
    .o_tx_flags(o_tx_flags), .o_tx_valid(o_tx_valid), .i_tx_ready(tx_ready),
    .o_tx_overflow(o_tx_overflow), .i_rx_ref_clock(rref), .o_rx_ddr_clock(o_rx_ddr_clock),
    .o_rx_lane_word(o_rx_lane_word), .o_rx_ctrl_flags(o_rx_ctrl_flags), .i_rx_word(rx_word),
    .i_rx_flags(rx_flags), .i_rx_valid(rx_valid), .o_rx_ready(o_rx_ready),
    .o_rx_underrun(o_rx_underrun));
  task automatic summarize();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Valid is held across back-to-back pushes and while the buffer refuses.
  task automatic push(input logic [PAIR_W+PFLAG_W-1:0] x);
    rx_valid = 1'b1;
    rx_word  = x[PAIR_W-1:0];
    rx_flags = x[PAIR_W+PFLAG_W-1:PAIR_W];
    while (o_rx_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 rxq.push_back(x);
  endtask
  function automatic logic [PAIR_W+PFLAG_W-1:0] rnd(input int i);
    rnd = {8'($urandom), $urandom, $urandom};
    if (i == 0) rnd[PAIR_W+PFLAG_W-1:PAIR_W] = 8'hff;
    if (i == 1) rnd[PAIR_W+PFLAG_W-1:PAIR_W] = 8'h00;
  endfunction
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Pops are judged at the falling edge, where ready and valid have settled.
  always @(negedge clk) begin
    if (o_tx_overflow === 1'b1) ovf++;
    if (o_rx_underrun === 1'b1) und_q = 1'b1;
    if (o_tx_valid === 1'b1 && tx_ready) begin
      if (txq.size() == 0) `CHK("tx_extra", 1'b0, 1'b1)
      else begin
        cur = txq.pop_front();
        `CHK("tx_word", cur[PAIR_W-1:0], o_tx_word)
        `CHK("tx_flags", cur[PAIR_W+PFLAG_W-1:PAIR_W], o_tx_flags)
      end
    end
    if (nrst && o_rx_ddr_clock !== rclk_q) begin
      rclk_q = o_rx_ddr_clock;
      rxe++;
      if (rclk_q) begin
        // An empty model queue means the buffer is empty too, since pushes are logged first.
        idl = rxq.size() == 0
          || (o_rx_lane_word === IDLE_WORD && o_rx_ctrl_flags === IDLE_FLAGS);
        if (idl) e = {IDLE_FLAGS, IDLE_FLAGS, IDLE_WORD, IDLE_WORD};
        else e = rxq.pop_front();
        `CHK("rx_underrun", idl, und_q)
        und_q = 1'b0;
        `CHK("rx_lo", e[LANE_W-1:0], o_rx_lane_word)
        `CHK("rx_lo_flags", e[PAIR_W+FLAG_W-1:PAIR_W], o_rx_ctrl_flags)
      end else begin
        `CHK("rx_hi", e[PAIR_W-1:LANE_W], o_rx_lane_word)
        `CHK("rx_hi_flags", e[PAIR_W+PFLAG_W-1:PAIR_W+FLAG_W], o_rx_ctrl_flags)
      end
    end
  end
  initial begin
    #100us fails++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_word = '0;
    rx_flags = '0;
    rclk_q = 1'b0;
    und_q = 1'b0;
    void'($urandom(92063));
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    `CHK("rst_valid", 1'b0, o_tx_valid)
    `CHK("rst_rx", IDLE_WORD, o_rx_lane_word)
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      t = rnd(i);
      txq.push_back(t);
      mac.send(t[PAIR_W-1:0], t[PAIR_W+PFLAG_W-1:PAIR_W]);
    end
    // Receiver stalls: the third pair meets a full buffer and is dropped.
    @(posedge clk);
    #1 tx_ready = 1'b0;
    for (int i = 0; i < 3; i++) begin
      t = rnd(i + 2);
      if (i < 2) txq.push_back(t);
      mac.send(t[PAIR_W-1:0], t[PAIR_W+PFLAG_W-1:PAIR_W]);
    end
    repeat (5) @(posedge clk);
    #1 tx_ready = 1'b1;
    repeat (10) @(posedge clk);
    `CHK("tx_drop", 1, ovf)
    `CHK("tx_left", 0, txq.size())
    // Step off the edge so that the first valid cannot race the capturing clock.
    #1;
    for (int i = 0; i < 6; i++) push(rnd(i));
    rx_valid = 1'b0;
    repeat (150) @(posedge clk);
    `CHK("rx_left", 0, rxq.size())
    `CHK("rxclk_runs", 1'b1, rxe > 20)
    summarize();
  end
endmodule
`default_nettype wire
